//--- bench/supply_monitor_tb.sv
// self-checking bench for the supply monitor control block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module supply_monitor_tb;
    // ********************
    // stimulus and outputs
    // ********************
    logic       i_clk = 1'b0;
    logic       i_resetn = 1'b0;
    logic       i_por = 1'b1;
    logic [3:0] lv = 4'ha; // {above 5v, below 5v, above 3v, below 3v}
    logic       i_stop_mode = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic       o_sys_reset, o_rst_pin_n, o_wake, o_range_5v, o_monitor_on, o_irq;
    logic [7:0] rd_q[$];
    logic [7:0] rd_exp;
    logic       rd_pend = 1'b0;
    logic       wake_seen = 1'b0;
    int         error_cnt = 0;
    int         tests_run = 0;
    always #5 i_clk = ~i_clk;
    supply_monitor dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_por(i_por), .i_below_fall_3v(lv[0]),
        .i_above_rise_3v(lv[1]), .i_below_fall_5v(lv[2]), .i_above_rise_5v(lv[3]), .i_stop_mode(i_stop_mode),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_sys_reset(o_sys_reset), .o_rst_pin_n(o_rst_pin_n), .o_wake(o_wake), .o_range_5v(o_range_5v),
        .o_monitor_on(o_monitor_on), .o_irq(o_irq));
    // ********************
    // read data watcher: data stand only in the cycle after the strobe
    // ********************
    always @(negedge i_clk) begin
        if (rd_pend) begin
            rd_exp = rd_q.pop_front();
            `CHK("rdata", rd_exp, o_rdata)
        end
        rd_pend = i_rd;
    end
    // ********************
    // bus and supply tasks
    // ********************
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b0;
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= a;
        rd_q.push_back(e);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) begin
            @(posedge i_clk);
            i_wr <= 1'b0;
            i_rd <= 1'b0;
        end
        @(negedge i_clk);
    endtask : settle
    // comparators need 4 edges to reach the reset request; 6 leaves margin
    task automatic supply(input logic [3:0] v);
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        lv <= v;
        repeat (6) begin
            @(negedge i_clk);
            wake_seen = wake_seen | o_wake;
        end
    endtask : supply
    task automatic chk_rst(input logic e);
        `CHK("sys_reset", e, o_sys_reset)
        `CHK("rst_pin_n", ~e, o_rst_pin_n)
    endtask : chk_rst
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // the whole sequence needs well under a thousand cycles
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        logic [7:0] d;
        void'($urandom(80706));
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        i_por <= 1'b0;
        settle(2);
        `CHK("monitor_on", 1'b1, o_monitor_on)
        rd(supply_monitor_pkg::OFF_CONFIG, supply_monitor_pkg::CFG_RESET);
        rd(supply_monitor_pkg::OFF_STATUS, 8'h00);
        supply(4'h5);
        chk_rst(1'b1);
        rd(supply_monitor_pkg::OFF_STATUS, 8'h80);
        supply(4'h0);
        chk_rst(1'b1);
        rd(supply_monitor_pkg::OFF_STATUS, 8'h80);
        supply(4'ha);
        chk_rst(1'b0);
        rd(supply_monitor_pkg::OFF_STATUS, 8'h00);
        `CHK("wake", 1'b0, wake_seen)
        // polled use with the event interrupt
        wr(supply_monitor_pkg::OFF_CONFIG, 8'h02);
        wr(supply_monitor_pkg::OFF_EVT_CL, 8'h03);
        wr(supply_monitor_pkg::OFF_EVT_EN, 8'h01);
        rd(supply_monitor_pkg::OFF_EVT, 8'h00);
        supply(4'h5);
        chk_rst(1'b0);
        `CHK("irq", 1'b1, o_irq)
        wr(supply_monitor_pkg::OFF_STATUS, 8'h00);
        rd(supply_monitor_pkg::OFF_STATUS, 8'h80);
        rd(supply_monitor_pkg::OFF_EVT, 8'h01);
        wr(supply_monitor_pkg::OFF_EVT_EN, 8'h00);
        settle(3);
        `CHK("irq", 1'b0, o_irq)
        wr(supply_monitor_pkg::OFF_EVT_EN, 8'h01);
        settle(3);
        `CHK("irq", 1'b1, o_irq)
        wr(supply_monitor_pkg::OFF_EVT_CL, 8'h01);
        settle(3);
        `CHK("irq", 1'b0, o_irq)
        supply(4'ha);
        // monitor powered down sees nothing
        wr(supply_monitor_pkg::OFF_CONFIG, 8'h01);
        supply(4'h5);
        `CHK("monitor_on", 1'b0, o_monitor_on)
        chk_rst(1'b0);
        rd(supply_monitor_pkg::OFF_STATUS, 8'h00);
        supply(4'ha);
        // stop mode with and without stop enable
        wr(supply_monitor_pkg::OFF_CONFIG, 8'h00);
        i_stop_mode <= 1'b1;
        supply(4'h5);
        chk_rst(1'b0);
        supply(4'ha);
        wr(supply_monitor_pkg::OFF_CONFIG, 8'h04);
        supply(4'h5);
        chk_rst(1'b1);
        `CHK("wake", 1'b1, wake_seen)
        supply(4'ha);
        i_stop_mode <= 1'b0;
        // range select: 5v chosen while below its rising level resets at once
        supply(4'h2);
        chk_rst(1'b0);
        wr(supply_monitor_pkg::OFF_CONFIG, 8'h08);
        settle(6);
        `CHK("range_5v", 1'b1, o_range_5v)
        chk_rst(1'b1);
        supply(4'ha);
        chk_rst(1'b0);
        supply(4'h6);
        chk_rst(1'b1);
        @(posedge i_clk);
        i_por <= 1'b1;
        @(posedge i_clk);
        i_por <= 1'b0;
        settle(6);
        `CHK("range_5v", 1'b0, o_range_5v)
        chk_rst(1'b0);
        rd(supply_monitor_pkg::OFF_CONFIG, 8'h00);
        // unmapped places ignore writes and read zero
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            wr(4'h8 + 4'(i), d);
            rd(4'h8 + 4'(i), 8'h00);
        end
        settle(3);
        wrap_up();
    end
endmodule : supply_monitor_tb

//--- hdl/hyst_flag.sv
// hysteresis latch: set below falling, clear above rising
`timescale 1ns/1ps
module hyst_flag (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_en,
    input  wire logic i_below_fall,
    input  wire logic i_above_rise,
    output logic      o_flag
);
    logic flag_r;
    logic flag_nxt;
    // below-falling wins if both ever show at once
    assign flag_nxt = !i_en ? 1'b0 : i_below_fall ? 1'b1 : i_above_rise ? 1'b0 : flag_r;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end
    assign o_flag = flag_r;
endmodule : hyst_flag

//--- hdl/supply_monitor.sv
// supply monitor control: config, status flag, reset request, event irq
`timescale 1ns/1ps
// How it works
// - config resets to zero, so monitoring is on straight out of reset
// - power-disable bit set turns the monitor off and blocks flag and reset
// - reset-disable clear means a low supply requests system reset
// - in stop mode the monitor runs only if stop-enable is set
// - range bit selects the 5 V comparator pair, clear selects 3 V
// - every power-on reset clears the range bit; software sets it again
// - setting 5 V while not above its rising level gives reset at once
// - a monitor reset holds until supply rises above the rising level
// - the status flag follows the comparator hysteresis result
// - a monitor reset also drives the external reset pin low
// - status flag is read-only, set below falling level, cleared by reset
// - flag is 0 above rising, 1 below falling, holds in between on 3 V; on 5 V it is 1 whenever not above rising
// - a monitor reset in stop mode wakes the part via the reset vector
// - the monitor raises a cpu interrupt request on o_irq only for enabled events
module supply_monitor (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_por,
    // comparator trips, asynchronous
    input  wire logic       i_below_fall_3v,
    input  wire logic       i_above_rise_3v,
    input  wire logic       i_below_fall_5v,
    input  wire logic       i_above_rise_5v,
    // system mode
    input  wire logic       i_stop_mode,
    // register port
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata,
    // reset, wake and monitor state outputs
    output logic            o_sys_reset,
    output logic            o_rst_pin_n,
    output logic            o_wake,
    output logic            o_range_5v,
    output logic            o_monitor_on,
    // event interrupt
    output logic            o_irq
);
    // ************************************************************
    // configuration
    // ************************************************************
    logic [7:0] cfg_r;
    logic [supply_monitor_pkg::EVT_W-1:0] evt_r;
    logic [supply_monitor_pkg::EVT_W-1:0] evt_en_r;
    logic [7:0] rdata_r;
    logic       sys_reset_r;
    logic       wake_r;
    logic       irq_r;
    logic       range_r;
    logic       on_r;
    logic       flag_prev_r;
    logic       rst_prev_r;
    logic       rst_pin_r;

    wire wr_cfg = i_wr && (i_addr == supply_monitor_pkg::OFF_CONFIG);
    wire wr_en  = i_wr && (i_addr == supply_monitor_pkg::OFF_EVT_EN);
    wire wr_clr = i_wr && (i_addr == supply_monitor_pkg::OFF_EVT_CL);

    // range bit is cleared only by power-on, other resets keep it
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_r <= supply_monitor_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            cfg_r <= i_wdata & 8'h0f;
        end
    end

    logic range_bit_r;
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            range_bit_r <= 1'b0;
        end else if (wr_cfg && i_resetn) begin
            range_bit_r <= i_wdata[supply_monitor_pkg::CFG_RANGE];
        end
    end

    wire pwrd   = cfg_r[supply_monitor_pkg::CFG_PWRD];
    wire rstd   = cfg_r[supply_monitor_pkg::CFG_RSTD];
    wire stopen = cfg_r[supply_monitor_pkg::CFG_STOP];
    wire range_sel = range_bit_r === 1'b1;

    // ************************************************************
    // comparator synchronisation
    // ************************************************************
    // bit order: {above 5v, below 5v, above 3v, below 3v}
    wire  [3:0] trip_async = {i_above_rise_5v, i_below_fall_5v, i_above_rise_3v, i_below_fall_3v};
    logic [3:0] trip_s;

    // each bit crosses alone; skew between bits only delays the flag one edge
    for (genvar g = 0; g < 4; g++) begin : g_sync
        trip_sync #(
            .STAGES(supply_monitor_pkg::SYNC_STAGES)
        ) u_sync (
            .i_clk   (i_clk),
            .i_resetn(i_resetn),
            .i_async (trip_async[g]),
            .o_sync  (trip_s[g])
        );
    end

    wire bf3_s = trip_s[0];
    wire ar3_s = trip_s[1];
    wire bf5_s = trip_s[2];
    wire ar5_s = trip_s[3];

    // ************************************************************
    // monitor enable and range
    // ************************************************************
    wire mon_on     = !pwrd && (!i_stop_mode || stopen);
    wire below_fall = range_sel ? bf5_s : bf3_s;
    wire above_rise = range_sel ? ar5_s : ar3_s;
    // 5 V selected while not above its rising level counts as low at once
    wire low_5v_sel = range_sel && !ar5_s;
    wire below_eff  = below_fall || low_5v_sel;

    logic flag;
    hyst_flag u_flag (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_en        (mon_on),
        .i_below_fall(below_eff),
        .i_above_rise(above_rise),
        .o_flag      (flag)
    );

    // ************************************************************
    // reset request
    // ************************************************************
    // the held flag is itself the reset source, so the hold follows hysteresis
    wire rst_req = mon_on && !rstd && flag;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sys_reset_r <= 1'b0;
            wake_r      <= 1'b0;
            range_r     <= 1'b0;
            on_r        <= 1'b0;
            flag_prev_r <= 1'b0;
            rst_prev_r  <= 1'b0;
            rst_pin_r   <= 1'b1;
        end else begin
            sys_reset_r <= rst_req;
            wake_r      <= rst_req && i_stop_mode;
            range_r     <= range_sel;
            on_r        <= mon_on;
            flag_prev_r <= flag;
            rst_prev_r  <= rst_req;
            // own flop, so no gate sits between the register and the pad
            rst_pin_r   <= !rst_req;
        end
    end

    // ************************************************************
    // event status, enable, clear; events never reach the cpu on their own
    // ************************************************************
    wire [supply_monitor_pkg::EVT_W-1:0] evt_set = {rst_req && !rst_prev_r, flag && !flag_prev_r};
    wire [supply_monitor_pkg::EVT_W-1:0] evt_clr = wr_clr ? i_wdata[supply_monitor_pkg::EVT_W-1:0] : '0;
    wire [supply_monitor_pkg::EVT_W-1:0] evt_nxt = (evt_r & ~evt_clr) | evt_set;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            evt_r    <= '0;
            evt_en_r <= '0;
            irq_r    <= 1'b0;
        end else begin
            evt_r    <= evt_nxt;
            irq_r    <= |(evt_nxt & (wr_en ? i_wdata[supply_monitor_pkg::EVT_W-1:0] : evt_en_r));
            if (wr_en) begin
                evt_en_r <= i_wdata[supply_monitor_pkg::EVT_W-1:0];
            end
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (i_addr)
            supply_monitor_pkg::OFF_STATUS: rd_mux = {flag, 7'h00};
            supply_monitor_pkg::OFF_CONFIG: rd_mux = {4'h0, range_sel, cfg_r[2:0]};
            supply_monitor_pkg::OFF_EVT:    rd_mux = {6'h00, evt_r};
            supply_monitor_pkg::OFF_EVT_EN: rd_mux = {6'h00, evt_en_r};
            default:                        rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= i_rd ? rd_mux : 8'h00;
        end
    end

    assign o_rdata      = rdata_r;
    assign o_sys_reset  = sys_reset_r;
    assign o_rst_pin_n  = rst_pin_r;
    assign o_wake       = wake_r;
    assign o_range_5v   = range_r;
    assign o_monitor_on = on_r;
    assign o_irq        = irq_r;

    // ************************************************************
    // checks
    // ************************************************************
    // reset path
    pin_follows_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_rst_pin_n == !o_sys_reset) else $error("reset pin not low with reset");

    pin_low_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        rst_req |=> !o_rst_pin_n) else $error("reset pin not driven low");

    reset_req_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (mon_on && !rstd && flag) |=> o_sys_reset) else $error("missing monitor reset");

    no_rst_dis_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        rstd |=> !rst_prev_r) else $error("reset while disabled");

    rst_release_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !rst_req |=> !o_sys_reset) else $error("reset held without request");

    no_rst_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !mon_on |=> !o_sys_reset) else $error("reset while monitor off");

    low5v_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (mon_on && !rstd && range_sel && !ar5_s) |=> ##1 o_sys_reset) else $error("5v low no reset");

    wake_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (rst_req && i_stop_mode) |=> o_wake) else $error("no wake on stop reset");

    wake_stop_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_stop_mode |=> !o_wake) else $error("wake outside stop");

    // flag and comparators
    off_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        pwrd |=> !flag) else $error("flag set while monitor off");

    stop_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_stop_mode && !stopen) |=> !flag) else $error("monitor ran in stop");

    flag_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (mon_on && below_eff) |=> flag) else $error("flag not set below falling");

    flag_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (mon_on && !below_eff && !above_rise) |=> flag == $past(flag)) else $error("flag lost hold");

    flag_rise_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (mon_on && !below_eff && above_rise) |=> !flag) else $error("flag not cleared above");

    hyst_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (flag && mon_on && !above_rise) |=> flag) else $error("flag left before rising level");

    sync_delay_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(bf3_s) |-> $past(i_below_fall_3v, 2)) else $error("trip passed too few stages");

    // configuration and range
    range_out_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        1'b1 |=> o_range_5v == $past(range_sel)) else $error("range output stale");

    por_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_por |=> !range_sel) else $error("range kept over power-on");

    mon_out_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        1'b1 |=> o_monitor_on == $past(mon_on)) else $error("monitor state output stale");

    // register port and events
    rdata_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_rd |=> o_rdata == 8'h00) else $error("read data without read");

    status_rd_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_rd && i_addr == supply_monitor_pkg::OFF_STATUS) |=> o_rdata[7] == $past(flag))
        else $error("status read wrong");

    cfg_rd_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_rd && i_addr == supply_monitor_pkg::OFF_CONFIG) |=> o_rdata[3] == $past(range_sel))
        else $error("range bit read wrong");

    status_ro_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_wr && i_addr == supply_monitor_pkg::OFF_STATUS) |=> $stable(cfg_r)) else $error("status write landed");

    sticky_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (evt_r[0] && !wr_clr) |=> evt_r[0]) else $error("event bit dropped");

    evt_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (flag && !flag_prev_r) |=> evt_r[0]) else $error("flag event not recorded");

    evt_clr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (wr_clr && i_wdata[0] && !(flag && !flag_prev_r)) |=> !evt_r[0]) else $error("event not cleared");
endmodule : supply_monitor

//--- hdl/supply_monitor_pkg.sv
// shared constants for the supply monitor block
package supply_monitor_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [3:0] OFF_STATUS = 4'h0;
    localparam logic [3:0] OFF_CONFIG = 4'h1;
    localparam logic [3:0] OFF_EVT    = 4'h2;
    localparam logic [3:0] OFF_EVT_EN = 4'h3;
    localparam logic [3:0] OFF_EVT_CL = 4'h4;
    // ************************************************************
    // config field positions
    // ************************************************************
    localparam int CFG_PWRD  = 0;
    localparam int CFG_RSTD  = 1;
    localparam int CFG_STOP  = 2;
    localparam int CFG_RANGE = 3;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // ************************************************************
    // status and event fields
    // ************************************************************
    localparam int STS_FLAG  = 7;
    localparam int EVT_FALL  = 0;
    localparam int EVT_RST   = 1;
    localparam int EVT_W     = 2;
    localparam int SYNC_STAGES = 2;
endpackage : supply_monitor_pkg

//--- hdl/trip_sync.sv
// two flip-flop synchroniser for one comparator bit
`timescale 1ns/1ps
module trip_sync #(
    parameter int STAGES = 2
) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_async,
    output logic      o_sync
);
    logic [STAGES-1:0] chain_r;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            chain_r <= '0;
        end else begin
            chain_r <= {chain_r[STAGES-2:0], i_async};
        end
    end
    assign o_sync = chain_r[STAGES-1];
endmodule : trip_sync
